// ===== include/sbsc_pkg.sv
// ==========================================================================
// cycle control package
package sbsc_pkg;

    localparam int ADDR_W_DEF = 20;
    localparam int LANES_DEF  = 4;
    localparam logic [1:0] BURST_INC   = 2'h1;
    localparam logic [1:0] BURST_RST   = 2'h0;
    localparam logic [1:0] ORDER_LIN_N = 2'h0;

    typedef enum logic [2:0]
    {
        SBSC_DESEL = 3'h0,
        SBSC_BEGIN = 3'h1,
        SBSC_NEXT  = 3'h2,
        SBSC_HOLD  = 3'h3
    } sbsc_cycle_e;

    // registered control pins, sampled on every rising edge
    typedef struct packed
    {
        logic       ce1_n;
        logic       ce2;
        logic       ce3_n;
        logic       padsp_n;
        logic       cadsc_n;
        logic       adv_n;
        logic       gw_n;
        logic       bw_n;
        logic [3:0] be_n;
    } sbsc_ctl_s;

endpackage

// ===== rtl/sbsc_cycle_ctrl.sv
`timescale 1ns/1ps
// ==========================================================================
// How it works
// - a strobe that starts a cycle while the combined enable is false deselects and floats data.
// - processor strobe with enable begins a read; controller strobe alone begins a read if no write.
// - controller strobe alone with enable and write condition begins a write burst.
// - with no strobe starting a cycle and advance low the burst address steps forward.
// - with no strobe starting a cycle and advance high the current burst address is held.
// - while the first chip enable is high the processor strobe is ignored.
// - the output enable gates read drivers asynchronously and never enables them otherwise.
// - a read with output enable high still advances the burst counter.
// - every listed input combination is decoded, optional ones included.
// - write is global write low or byte write low with any byte enable low.
// - the two low bits step in linear or interleaved order and wrap after four.
module sbsc_cycle_ctrl
#(
    parameter int ADDR_W = sbsc_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsc_pkg::LANES_DEF
)
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              chip_enable_first_n_in,
    input  wire logic              chip_enable_second_hi_in,
    input  wire logic              chip_enable_third_n_in,
    input  wire logic              processor_addr_strobe_n_in,
    input  wire logic              controller_addr_strobe_n_in,
    input  wire logic              burst_advance_n_in,
    input  wire logic              global_write_n_in,
    input  wire logic              byte_write_n_in,
    input  wire logic [LANES-1:0]  byte_enable_n_in,
    input  wire logic              linear_order_select_n_in,
    input  wire logic              output_enable_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic                   mem_read_out,
    output logic                   mem_write_out,
    output logic [LANES-1:0]       mem_lane_we_out,
    output logic                   selected_out,
    output logic                   dq_oe_out
);

    typedef struct packed
    {
        logic [ADDR_W-1:0] base;
        logic [1:0]        cnt;
        logic              sel;
        logic              rd;
        logic              wr;
        logic [LANES-1:0]  lane;
        logic [ADDR_W-1:0] ext;
        logic              lin_n;
        sbsc_pkg::sbsc_ctl_s c;
    } sbsc_state_s;

    sbsc_state_s q, d;
    logic        en_ok;
    logic        wr_cond;
    logic        start;
    sbsc_pkg::sbsc_cycle_e kind;

    // order pin is treated as static, so interleave is an xor of the count
    function automatic logic [1:0] burst_low(input logic [1:0] s,
                                             input logic [1:0] n,
                                             input logic lin_n);
        burst_low = (lin_n == 1'b0) ? 2'(s + n) : (s ^ n);
    endfunction

    // ======================================================================
    // decode from registered controls
    always_comb
    begin
        en_ok   = q.c.ce2 & ~q.c.ce1_n & ~q.c.ce3_n;
        wr_cond = ~q.c.gw_n | (~q.c.bw_n & ~(&q.c.be_n));
        // processor strobe counts only with first enable low
        start   = ~q.c.cadsc_n | (~q.c.padsp_n & ~q.c.ce1_n);
        if (start && !en_ok)
            kind = sbsc_pkg::SBSC_DESEL;
        else if (start)
            kind = sbsc_pkg::SBSC_BEGIN;
        else if (!q.c.adv_n)
            kind = sbsc_pkg::SBSC_NEXT;
        else
            kind = sbsc_pkg::SBSC_HOLD;
    end

    always_comb
    begin
        d       = q;
        d.lin_n = linear_order_select_n_in;
        d.ext   = addr_in;
        d.c     = '{ce1_n: chip_enable_first_n_in,
                    ce2: chip_enable_second_hi_in,
                    ce3_n: chip_enable_third_n_in,
                    padsp_n: processor_addr_strobe_n_in,
                    cadsc_n: controller_addr_strobe_n_in,
                    adv_n: burst_advance_n_in,
                    gw_n: global_write_n_in,
                    bw_n: byte_write_n_in,
                    be_n: byte_enable_n_in[3:0]};
        d.rd    = 1'b0;
        d.wr    = 1'b0;
        d.lane  = '0;
        case (kind)
            sbsc_pkg::SBSC_DESEL:
            begin
                d.sel = 1'b0;
            end
            sbsc_pkg::SBSC_BEGIN:
            begin
                d.sel  = 1'b1;
                d.base = q.ext;
                d.cnt  = sbsc_pkg::BURST_RST;
                // processor strobe start is always a read
                d.wr   = q.c.padsp_n & wr_cond;
                d.rd   = ~d.wr;
            end
            sbsc_pkg::SBSC_NEXT:
            begin
                // dummy reads step the same way; output enable is not seen
                d.cnt = 2'(q.cnt + sbsc_pkg::BURST_INC);
                d.wr  = q.sel & wr_cond;
                d.rd  = q.sel & ~wr_cond;
            end
            sbsc_pkg::SBSC_HOLD:
            begin
                d.wr = q.sel & wr_cond;
                d.rd = q.sel & ~wr_cond;
            end
            default:
            begin
                d.sel = 1'b0;
            end
        endcase
        if (d.wr)
            d.lane = q.c.gw_n ? ~q.c.be_n[LANES-1:0] : '1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q       <= '0;
            q.c     <= '1;
            q.lin_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign mem_addr_out    = {q.base[ADDR_W-1:2],
                              burst_low(q.base[1:0], q.cnt, q.lin_n)};
    assign mem_read_out    = q.rd;
    assign mem_write_out   = q.wr;
    assign mem_lane_we_out = q.lane;
    assign selected_out    = q.sel;
    assign dq_oe_out       = q.rd & ~output_enable_n_in;

    // ======================================================================
    // checks
    desel_float_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (kind == sbsc_pkg::SBSC_DESEL) |=> !selected_out && !dq_oe_out)
        else $error("deselect did not float");
    padsp_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (en_ok && !q.c.padsp_n) |=> mem_read_out && !mem_write_out)
        else $error("processor strobe start not a read");
    cadsc_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (en_ok && q.c.padsp_n && !q.c.cadsc_n && wr_cond)
        |=> mem_write_out && mem_addr_out == $past(q.ext))
        else $error("controller write start wrong");
    step_next_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && !q.c.adv_n) |=> q.cnt == 2'($past(q.cnt) + 2'h1))
        else $error("burst did not step");
    hold_addr_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && q.c.adv_n) |=> $stable(mem_addr_out))
        else $error("suspend moved address");
    ce1_ignore_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (q.c.ce1_n && q.c.cadsc_n) |-> kind != sbsc_pkg::SBSC_BEGIN)
        else $error("processor strobe honoured with enable high");
    oe_gate_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        dq_oe_out |-> mem_read_out && !output_enable_n_in)
        else $error("drivers on outside read");
    wrap_four_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && !q.c.adv_n) [*4] |=> mem_addr_out == $past(mem_addr_out, 4))
        else $error("burst did not wrap");
    lane_we_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        mem_write_out |-> mem_lane_we_out != '0 || !q.sel)
        else $error("write with no lanes");

    // ======================================================================
    // cycle type checks
    // the order pin is a mode pin; a change in mid burst moves the address,
    // so callers change it only right after a cycle start
    desel_nowr_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (kind == sbsc_pkg::SBSC_DESEL) |=> !mem_read_out && !mem_write_out)
        else $error("deselect still accessed memory");
    begin_load_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (start && en_ok) |=> selected_out && mem_addr_out == $past(q.ext))
        else $error("begin burst did not load address");
    cadsc_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (en_ok && q.c.padsp_n && !q.c.cadsc_n && !wr_cond)
        |=> mem_read_out && !mem_write_out)
        else $error("controller read start wrong");
    next_rw_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && !q.c.adv_n && q.sel)
        |=> mem_write_out == $past(wr_cond) && mem_read_out == !$past(wr_cond))
        else $error("continue cycle kind wrong");
    hold_rw_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && q.c.adv_n && q.sel)
        |=> mem_write_out == $past(wr_cond) && mem_read_out == !$past(wr_cond))
        else $error("suspend cycle kind wrong");
    dummy_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!start && !q.c.adv_n && q.rd && output_enable_n_in)
        |=> q.cnt == 2'($past(q.cnt) + 2'h1))
        else $error("dummy read did not step");
    ce1_desel_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (q.c.ce1_n && !q.c.cadsc_n) |-> kind == sbsc_pkg::SBSC_DESEL)
        else $error("enable high start not a deselect");
    no_bytes_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (start && en_ok && q.c.gw_n && !q.c.bw_n && (&q.c.be_n))
        |=> !mem_write_out)
        else $error("write with no bytes not a read");
    oe_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        output_enable_n_in |-> !dq_oe_out)
        else $error("drivers on with output enable high");

endmodule

// ===== verification/sbsc_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// host side of the output enable
module sbsc_host_model
(
    input  wire logic ref_clk_in,
    input  wire logic turn_in,
    input  wire logic want_in,
    output logic      oe_n_out
);
    // turn high or want low raises oe_n_out at the next edge; the bench raises turn only for global writes in test 3
    always_ff @(posedge ref_clk_in)
    begin
        oe_n_out <= turn_in | ~want_in;
    end
endmodule

// ===== verification/sync_burst_sram_cycle_control_test.sv
`timescale 1ns/1ps
// ==========================================================================
// bench with a reference model of the cycle decode
module sync_burst_sram_cycle_control_test;
    logic                ref_clk_in = 1'b0;
    logic                rst_n_in   = 1'b0;
    sbsc_pkg::sbsc_ctl_s c          = '1;
    sbsc_pkg::sbsc_ctl_s r;
    logic [19:0]         a          = '0;
    logic [19:0]         ra, base, ea, mem_addr;
    logic                linear_order_select_n = 1'b0, rl, turn = 1'b0, want = 1'b0, oe_n;
    logic                rd, wr, sel, dq, en, w, st, es, erd, ewr;
    logic [3:0]          we, ewe;
    int                  cnt, fail_count = 0, cmp_count = 0;

    sbsc_cycle_ctrl sbsc_cycle_ctrl_inst (
        .ref_clk_in                  (ref_clk_in),
        .rst_n_in                    (rst_n_in),
        .chip_enable_first_n_in      (c.ce1_n),
        .chip_enable_second_hi_in    (c.ce2),
        .chip_enable_third_n_in      (c.ce3_n),
        .processor_addr_strobe_n_in  (c.padsp_n),
        .controller_addr_strobe_n_in (c.cadsc_n),
        .burst_advance_n_in          (c.adv_n),
        .global_write_n_in           (c.gw_n),
        .byte_write_n_in             (c.bw_n),
        .byte_enable_n_in            (c.be_n),
        .linear_order_select_n_in    (linear_order_select_n),
        .output_enable_n_in          (oe_n),
        .addr_in                     (a),
        .mem_addr_out                (mem_addr),
        .mem_read_out                (rd),
        .mem_write_out               (wr),
        .mem_lane_we_out             (we),
        .selected_out                (sel),
        .dq_oe_out                   (dq)
    );
    sbsc_host_model sbsc_host_model_inst (
        .ref_clk_in (ref_clk_in),
        .turn_in    (turn),
        .want_in    (want),
        .oe_n_out   (oe_n)
    );

    initial
    begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk_f(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t flags got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_a(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t addr got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ======================================================================
    // reference model: inputs taken at one edge, result at the next
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            r = '0; ra = '0; rl = 1'b0; es = 0; erd = 0; ewr = 0; ewe = '0;
            cnt = 0; base = '0;
        end
        else
        begin
            en = r.ce2 & ~r.ce1_n & ~r.ce3_n;
            w  = ~r.gw_n | (~r.bw_n & ~&r.be_n);
            st = ~r.cadsc_n | (~r.padsp_n & ~r.ce1_n);
            if (st && !en) es = 0;
            else if (st) begin es = 1; base = ra; cnt = 0; end
            else if (!r.adv_n) cnt++;
            erd = es & ((st & ~r.padsp_n) | ~w);
            ewr = es & ~erd;
            ewe = ewr ? (r.gw_n ? ~r.be_n : 4'hF) : 4'h0;
            // the order pin is registered at this same edge in the design
            rl = linear_order_select_n;
            ea = {base[19:2], rl ? base[1:0] ^ 2'(cnt)
                                 : base[1:0] + 2'(cnt)};
            r = c; ra = a;
        end
    end

    always @(negedge ref_clk_in)
    begin
        if (rst_n_in)
        begin
            chk_f({rd, wr, we, sel, dq}, {erd, ewr, ewe, es, erd & ~oe_n});
            if (erd | ewr) chk_a(mem_addr, ea);
        end
    end

    // ======================================================================
    task automatic drive(input int m);
        sbsc_pkg::sbsc_ctl_s v;
        @(posedge ref_clk_in);
        v = sbsc_pkg::sbsc_ctl_s'(12'($urandom));
        if ($urandom % 4 != 0) {v.ce1_n, v.ce2, v.ce3_n} = 3'b010;
        if (m == 1) begin v.padsp_n = 1; v.adv_n = 0; v.cadsc_n = ($urandom % 4 != 0); end
        if (m == 2) begin v.padsp_n = 1; v.cadsc_n = 0; end
        c <= v;
        a <= 20'($urandom);
        want <= (m == 3) | 1'($urandom);
        turn <= (m == 3) & ~v.gw_n;
    endtask

    initial
    begin
        void'($urandom(32'hBA9F));
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            // order pin changes only just after a cycle start
            @(posedge ref_clk_in);
            c.cadsc_n <= 1'b0;
            @(posedge ref_clk_in);
            linear_order_select_n <= m[0];
            repeat (500) drive(m);
            $display("test %0d done, mismatches %0d", m, fail_count);
        end
        repeat (3) @(posedge ref_clk_in);
        tally_and_finish;
    end

    // whole run is about 2000 cycles; this limit is ten times that
    initial
    begin
        #80000;
        fail_count++;
        tally_and_finish;
    end
endmodule
